// File: ctmc_regs.vh
// Register offsets, field positions, reset values and bus response codes for the compact timer mode and compare control.
`ifndef CTMC_REGS_VH
`define CTMC_REGS_VH
// ==========================================================================
// Register byte addresses.
`define CTMC_ADDR_CTRL0      8'h00
`define CTMC_ADDR_CTRL1      8'h04
`define CTMC_ADDR_CNT_LO     8'h08
`define CTMC_ADDR_CNT_HI     8'h0C
`define CTMC_ADDR_CMPA_LO    8'h10
`define CTMC_ADDR_CMPA_HI    8'h14
`define CTMC_ADDR_FLAGS      8'h18
// ==========================================================================
// Field positions in the timer control register.
`define CTMC_C0_ON           3
`define CTMC_C0_PER_HI       2
`define CTMC_C0_PER_LO       0
// Field positions in the mode and output control register.
`define CTMC_C1_MODE_HI      7
`define CTMC_C1_MODE_LO      6
`define CTMC_C1_FUNC_HI      5
`define CTMC_C1_FUNC_LO      4
`define CTMC_C1_INIT         3
`define CTMC_C1_INV          2
`define CTMC_C1_SWAP         1
`define CTMC_C1_CLRSEL       0
// Flag register bits, write one to clear.
`define CTMC_FLAG_CMPA       0
`define CTMC_FLAG_PER        1
// ==========================================================================
// Modes and output functions.
`define CTMC_MODE_CMP        2'h0
`define CTMC_MODE_PWM        2'h2
`define CTMC_MODE_TMR        2'h3
`define CTMC_FN_NONE         2'h0
`define CTMC_FN_LOW          2'h1
`define CTMC_FN_HIGH         2'h2
`define CTMC_FN_TOGGLE       2'h3
// ==========================================================================
// Reset values, counter limits and bus response codes.
`define CTMC_RESET_BYTE      8'h00
`define CTMC_CNT_MAX         10'h3FF
`define CTMC_AXI_OKAY        2'h0
`define CTMC_AXI_SLVERR      2'h2
`endif

// File: ctmc_timer.v
// Compact 10-bit timer with mode, output and compare control behind an AXI4-Lite slave.
`timescale 1ns/1ps
`include "ctmc_regs.vh"
module ctmc_timer (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire        cnt_tick,
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  output reg         timer_output_pin,
  output reg         timer_output_pin_oe,
  output reg         compare_a_flag,
  output reg         period_match_flag
);
  // ========================================================================
  // Register state.
  reg  [7:0] timer_ctrl0;
  reg  [7:0] timer_mode_output_ctrl;
  reg  [9:0] counter;
  reg  [9:0] compare_a_value;
  reg  [7:0] wr_buffer;
  reg  [7:0] rd_buffer;
  reg        pin_level;
  reg        pwm_level;
  reg        on_d;
  reg        aw_held;
  reg        w_held;
  reg  [7:0] aw_addr;
  reg  [31:0] w_data;
  reg  [3:0] w_strb;

  wire [1:0] mode          = timer_mode_output_ctrl[`CTMC_C1_MODE_HI:`CTMC_C1_MODE_LO];
  wire [1:0] func          = timer_mode_output_ctrl[`CTMC_C1_FUNC_HI:`CTMC_C1_FUNC_LO];
  wire       init_level    = timer_mode_output_ctrl[`CTMC_C1_INIT];
  wire       invert        = timer_mode_output_ctrl[`CTMC_C1_INV];
  wire       swap          = timer_mode_output_ctrl[`CTMC_C1_SWAP];
  wire       clr_sel       = timer_mode_output_ctrl[`CTMC_C1_CLRSEL];
  wire [2:0] period_compare_field = timer_ctrl0[`CTMC_C0_PER_HI:`CTMC_C0_PER_LO];
  wire       timer_on      = timer_ctrl0[`CTMC_C0_ON];
  wire       on_rise       = timer_on & ~on_d;

  // ========================================================================
  // Comparators and clear selection.
  wire       run           = timer_on & cnt_tick;
  wire       per_zero      = (period_compare_field == 3'h0);
  wire       a_zero        = (compare_a_value == 10'h000);
  wire       at_max        = (counter == `CTMC_CNT_MAX);
  // Period match on the last count before the top three counter bits reach the field, or overflow for code zero.
  wire       per_hit       = per_zero ? at_max :
                             (counter[9:7] == period_compare_field - 3'h1) && (counter[6:0] == 7'h7F);
  wire       a_hit         = ~a_zero && (counter == compare_a_value - 10'h001);
  reg        clear_cnt;
  reg        per_flag_en;
  reg        a_flag_en;
  always @* begin
    if (mode == `CTMC_MODE_PWM) begin
      clear_cnt   = swap ? (a_hit | (a_zero & at_max)) : per_hit;
      per_flag_en = 1'b1;
      a_flag_en   = 1'b1;
    end else if (clr_sel) begin
      clear_cnt   = a_hit | (a_zero & at_max);
      per_flag_en = 1'b0;
      a_flag_en   = 1'b1;
    end else begin
      clear_cnt   = per_hit;
      per_flag_en = 1'b1;
      a_flag_en   = 1'b1;
    end
  end

  // ========================================================================
  // PWM duty compare; counter reaching duty ends the active phase.
  wire [9:0] duty_value = swap ? {period_compare_field, 7'h00} : compare_a_value;
  wire       pwm_active = (swap && per_zero) ? 1'b1 : (counter < duty_value);

  // ========================================================================
  // Byte access decode.
  wire       w_fire   = aw_held & w_held & ~s_axi_bvalid;
  wire       wr_lane  = w_strb[0];
  wire       wr_ctrl0 = w_fire & wr_lane & (aw_addr == `CTMC_ADDR_CTRL0);
  wire       wr_cmpa_hi = w_fire & wr_lane & (aw_addr == `CTMC_ADDR_CMPA_HI);

  // ========================================================================
  // Counter, flags and output pin.
  always @(posedge aclk) begin
    if (!aresetn) begin
      counter           <= 10'h000;
      on_d              <= 1'b0;
      compare_a_flag    <= 1'b0;
      period_match_flag <= 1'b0;
      pin_level         <= 1'b0;
      pwm_level         <= 1'b0;
    end else begin
      on_d <= timer_on;
      if (on_rise) begin
        counter   <= 10'h000;
        pin_level <= init_level;
      end else if (run) begin
        if (clear_cnt)
          counter <= 10'h000;
        else
          counter <= counter + 10'h001;
        // Output change on compare-A only; period match leaves the pin.
        if (a_hit && a_flag_en && mode == `CTMC_MODE_CMP) begin
          case (func)
            `CTMC_FN_LOW:    pin_level <= 1'b0;
            `CTMC_FN_HIGH:   pin_level <= 1'b1;
            `CTMC_FN_TOGGLE: pin_level <= ~pin_level;
            default:         pin_level <= pin_level;
          endcase
        end
      end
      // The PWM level follows the settled count every cycle.
      pwm_level <= pwm_active;
      // Hardware set wins over a software clear in the same cycle.
      if (run && a_hit && a_flag_en)
        compare_a_flag <= 1'b1;
      else if (w_fire && aw_addr == `CTMC_ADDR_FLAGS && wr_lane && w_data[`CTMC_FLAG_CMPA])
        compare_a_flag <= 1'b0;
      if (run && per_hit && per_flag_en)
        period_match_flag <= 1'b1;
      else if (w_fire && aw_addr == `CTMC_ADDR_FLAGS && wr_lane && w_data[`CTMC_FLAG_PER])
        period_match_flag <= 1'b0;
    end
  end

  // Pin drive by mode, registered straight onto the port.
  reg next_pin;
  reg next_oe;
  always @* begin
    next_pin = 1'b0;
    next_oe  = 1'b0;
    case (mode)
      `CTMC_MODE_CMP: begin
        next_pin = pin_level ^ invert;
        next_oe  = 1'b1;
      end
      `CTMC_MODE_PWM: begin
        case (func)
          `CTMC_FN_NONE: next_pin = ~init_level;
          `CTMC_FN_LOW:  next_pin = init_level;
          `CTMC_FN_HIGH: next_pin = pwm_level ? init_level : ~init_level;
          default:       next_pin = ~init_level;
        endcase
        next_pin = next_pin ^ invert;
        next_oe  = 1'b1;
      end
      default: begin
        next_pin = 1'b0;
        next_oe  = 1'b0;
      end
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      timer_output_pin    <= 1'b0;
      timer_output_pin_oe <= 1'b0;
    end else begin
      timer_output_pin    <= next_pin;
      timer_output_pin_oe <= next_oe;
    end
  end

  // ========================================================================
  // AXI4-Lite write channel.
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready          <= 1'b0;
      s_axi_wready           <= 1'b0;
      s_axi_bvalid           <= 1'b0;
      s_axi_bresp            <= `CTMC_AXI_OKAY;
      aw_held                <= 1'b0;
      w_held                 <= 1'b0;
      aw_addr                <= 8'h00;
      w_data                 <= 32'h0000_0000;
      w_strb                 <= 4'h0;
      timer_ctrl0            <= `CTMC_RESET_BYTE;
      timer_mode_output_ctrl <= `CTMC_RESET_BYTE;
      compare_a_value        <= 10'h000;
      wr_buffer              <= `CTMC_RESET_BYTE;
    end else begin
      s_axi_awready <= ~aw_held & ~s_axi_awready & ~s_axi_bvalid & s_axi_awvalid;
      s_axi_wready  <= ~w_held & ~s_axi_wready & ~s_axi_bvalid & s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (w_fire) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (aw_addr > `CTMC_ADDR_FLAGS || aw_addr[1:0] != 2'h0) ? `CTMC_AXI_SLVERR : `CTMC_AXI_OKAY;
        if (wr_ctrl0)
          timer_ctrl0 <= w_data[7:0];
        if (wr_lane && aw_addr == `CTMC_ADDR_CTRL1)
          timer_mode_output_ctrl <= w_data[7:0];
        if (wr_lane && aw_addr == `CTMC_ADDR_CMPA_LO)
          wr_buffer <= w_data[7:0];
        if (wr_cmpa_hi)
          compare_a_value <= {w_data[1:0], wr_buffer};
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ========================================================================
  // AXI4-Lite read channel.
  reg [7:0] rd_byte;
  always @* begin
    case (s_axi_araddr)
      `CTMC_ADDR_CTRL0:   rd_byte = timer_ctrl0;
      `CTMC_ADDR_CTRL1:   rd_byte = timer_mode_output_ctrl;
      `CTMC_ADDR_CNT_LO:  rd_byte = rd_buffer;
      `CTMC_ADDR_CNT_HI:  rd_byte = {6'h00, counter[9:8]};
      `CTMC_ADDR_CMPA_LO: rd_byte = rd_buffer;
      `CTMC_ADDR_CMPA_HI: rd_byte = {6'h00, compare_a_value[9:8]};
      `CTMC_ADDR_FLAGS:   rd_byte = {6'h00, period_match_flag, compare_a_flag};
      default:            rd_byte = 8'h00;
    endcase
  end
  wire rd_map = (s_axi_araddr <= `CTMC_ADDR_FLAGS) && (s_axi_araddr[1:0] == 2'h0);

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `CTMC_AXI_OKAY;
      rd_buffer     <= `CTMC_RESET_BYTE;
    end else begin
      s_axi_arready <= s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= {24'h000000, rd_byte};
        s_axi_rresp  <= rd_map ? `CTMC_AXI_OKAY : `CTMC_AXI_SLVERR;
        if (s_axi_araddr == `CTMC_ADDR_CNT_HI)
          rd_buffer <= counter[7:0];
        if (s_axi_araddr == `CTMC_ADDR_CMPA_HI)
          rd_buffer <= compare_a_value[7:0];
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule // ctmc_timer

// File: ctmc_asserts.sv
// Port-level checks on the compact timer register bus and the compare-A flag.
`timescale 1ns/1ps
module ctmc_asserts (
  input wire        aclk,
  input wire        aresetn,
  input wire        cnt_tick,
  input wire        s_axi_awready,
  input wire        s_axi_wready,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire        s_axi_arready,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  input wire [31:0] s_axi_rdata,
  input wire        compare_a_flag
);
  // ========
  // Handshake, read data and flag timing.
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  aw_pulse_a: assert property (s_axi_awready |=> !s_axi_awready) else $error("awready too long");
  w_pulse_a: assert property (s_axi_wready |=> !s_axi_wready) else $error("wready too long");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("bvalid dropped");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid) else $error("rvalid dropped");
  r_held_a: assert property (s_axi_rvalid && !s_axi_rready |=> $stable(s_axi_rdata)) else $error("rdata moved");
  b_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("write taken");
  ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read taken");
  r_after_ar_a: assert property (s_axi_arready |=> s_axi_rvalid) else $error("late read data");
  r_byte_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
    else $error("wide read data");
  a_flag_tick_a: assert property ($rose(compare_a_flag) |-> $past(cnt_tick) || $past(cnt_tick, 2))
    else $error("flag without tick");
endmodule // ctmc_asserts

// File: tb_compact_timer_mode_and_compare_control.sv
// Self-checking bench for the compact timer with an integer count model.
`timescale 1ns/1ps
module tb_compact_timer_mode_and_compare_control;
  // ========
  // Stimulus, responses, design and tasks.
  reg         aclk = 1'b0, aresetn = 1'b0, tck = 1'b0, awv = 1'b0, wv = 1'b0;
  reg         br = 1'b0, arv = 1'b0, rr = 1'b0;
  reg  [7:0]  awa = 8'h00, ara = 8'h00;
  reg  [31:0] wd = 32'h00000000;
  reg  [1:0]  resp;
  wire        awrdy, wrdy, bv, arrdy, rv, pin, oe, fa, fp;
  wire [1:0]  bre, rre;
  wire [31:0] rdat;
  integer     seed = 32'h8612, miscompares = 0, n_tests = 0, c, f, s, e, k, p, v;
  ctmc_timer u_ctmc_timer (.aclk(aclk), .aresetn(aresetn), .cnt_tick(tck), .s_axi_awaddr(awa),
    .s_axi_awvalid(awv), .s_axi_awready(awrdy), .s_axi_wdata(wd), .s_axi_wstrb(4'h1), .s_axi_wvalid(wv),
    .s_axi_wready(wrdy), .s_axi_bresp(bre), .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ara),
    .s_axi_arvalid(arv), .s_axi_arready(arrdy), .s_axi_rdata(rdat), .s_axi_rresp(rre), .s_axi_rvalid(rv),
    .s_axi_rready(rr), .timer_output_pin(pin), .timer_output_pin_oe(oe), .compare_a_flag(fa),
    .period_match_flag(fp));
  always #25 aclk = ~aclk;
  task chk(input [31:0] seen, input [31:0] exp);
    n_tests = n_tests + 1;
    if (seen !== exp) begin
      miscompares = miscompares + 1;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task test_done;
    $display("checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task bus(input w, input [7:0] a, input [7:0] d, input [31:0] exp);
    integer n;
    awa <= a;
    ara <= a;
    wd <= {24'h000000, d};
    awv <= w;
    wv <= w;
    br <= w;
    arv <= !w;
    rr <= !w;
    for (n = 0; n < 40; n = n + 1) begin
      @(posedge aclk);
      if (awrdy) awv <= 1'b0;
      if (wrdy) wv <= 1'b0;
      if (arrdy) arv <= 1'b0;
      if (bv || rv) n = 99;
    end
    resp = w ? bre : rre;
    if (!w) chk(rdat, exp);
    br <= 1'b0;
    rr <= 1'b0;
    @(posedge aclk);
    if (n == 40) chk(32'h1, 32'h0);
    if (n == 40) test_done;
  endtask
  task tick(input integer n);
    integer j;
    for (j = 0; j < n; j = j + 1) begin
      tck <= 1'b1;
      @(posedge aclk);
      tck <= 1'b0;
      @(posedge aclk);
    end
    repeat (3) @(posedge aclk);
  endtask
  task cnt(input integer x);
    bus(0, 8'h0C, 8'h00, x >> 8);
    bus(0, 8'h08, 8'h00, x & 255);
  endtask
  task start(input [7:0] c1, input [7:0] c0);
    bus(1, 8'h00, 8'h00, 0);
    bus(1, 8'h04, c1, 0);
    bus(1, 8'h18, 8'h03, 0);
    bus(1, 8'h00, c0, 0);
    tick(0);
  endtask
  // ========
  // Main sequence.
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    for (k = 0; k < 7; k = k + 1)
      bus(0, 8'(k * 4), 8'h00, 0);
    bus(0, 8'h1C, 8'h00, 0);
    chk(32'(resp), 2);
    bus(1, 8'h1C, 8'h00, 0);
    chk(32'(resp), 2);
    bus(1, 8'h08, 8'hA5, 0);
    chk(32'(resp), 0);
    cnt(0);
    $display("test 1 done");
    for (k = 0; k < 4; k = k + 1) begin
      v = $random(seed) & 255;
      bus(1, 8'h04, 8'(v), 0);
      bus(0, 8'h04, 8'h00, v);
    end
    v = $random(seed) & 1023;
    bus(1, 8'h10, 8'(v), 0);
    bus(0, 8'h14, 8'h00, 0);
    bus(0, 8'h10, 8'h00, 0);
    bus(1, 8'h14, 8'(v >> 8) | 8'hFC, 0);
    bus(0, 8'h14, 8'h00, v >> 8);
    bus(0, 8'h10, 8'h00, v & 255);
    $display("test 2 done");
    for (c = 0; c < 8; c = c + 1) begin
      p = (c == 0) ? 1024 : c * 128;
      start(8'h00, 8'(8 + c));
      chk(32'(fp), 0);
      tick(p + 3);
      cnt(3);
      chk(32'(fp), 1);
    end
    bus(1, 8'h00, 8'h00, 0);
    tick(5);
    cnt(3);
    $display("test 3 done");
    bus(1, 8'h10, 8'h05, 0);
    bus(1, 8'h14, 8'h00, 0);
    for (k = 0; k < 16; k = k + 1) begin
      f = k & 3;
      s = k >> 2 & 1;
      e = k >> 3;
      start(8'(f * 16 + s * 8 + e * 4 + 1), 8'h08);
      chk(32'(pin), s ^ e);
      tick(5);
      chk(32'(pin), ((f == 0) ? s : (f == 1) ? 0 : (f == 2) ? 1 : 1 - s) ^ e);
      chk(32'(fa), 1);
    end
    cnt(0);
    bus(1, 8'h10, 8'h00, 0);
    bus(1, 8'h14, 8'h00, 0);
    start(8'h01, 8'h08);
    tick(1027);
    cnt(3);
    chk(32'(fa), 0);
    for (k = 0; k < 4; k = k + 1) begin
      start(8'(k * 64), 8'h08);
      chk(32'(oe), (k == 0 || k == 2) ? 1 : 0);
    end
    $display("test 4 done");
    for (s = 0; s < 2; s = s + 1) begin
      p = s ? 200 : 128;
      e = s ? 128 : 32;
      bus(1, 8'h10, 8'(s ? 200 : 32), 0);
      bus(1, 8'h14, 8'h00, 0);
      start(8'(8'hA9 + s * 2), 8'h09);
      for (k = 1; k < 13; k = k + 1) begin
        tick(20);
        chk(32'(pin), ((k * 20) % p < e) ? 1 : 0);
      end
    end
    for (k = 0; k < 8; k = k + 1) begin
      f = k & 1;
      s = k >> 1 & 1;
      e = k >> 2;
      start(8'(8'h80 + f * 16 + s * 8 + e * 4), 8'h09);
      chk(32'(pin), (f ? s : 1 - s) ^ e);
    end
    $display("test 5 done");
    test_done;
  end
endmodule // tb_compact_timer_mode_and_compare_control
bind ctmc_timer ctmc_asserts u_ctmc_asserts (.aclk(aclk), .aresetn(aresetn), .cnt_tick(cnt_tick),
  .s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .compare_a_flag(compare_a_flag));
